//--- hdl/pin_config_pkg.sv
// Constants for the SPI address map and output pin configuration block
package pin_config_pkg;
  // Header byte layout
  localparam int HdrRwBit = 7;
  localparam int HdrBurstBit = 6;
  // Register offsets
  localparam logic [5:0] AddrPin2Cfg = 6'h00;
  localparam logic [5:0] AddrPin1Cfg = 6'h01;
  localparam logic [5:0] AddrPin0Cfg = 6'h02;
  localparam logic [5:0] AddrCfgLast = 6'h2E;
  localparam logic [5:0] AddrStrobeFirst = 6'h30;
  localparam logic [5:0] AddrStrobeLast = 6'h3D;
  localparam logic [5:0] AddrPartNum = 6'h30;
  localparam logic [5:0] AddrVersion = 6'h31;
  // Field positions in the pin configuration registers
  localparam int DriveBit = 7;
  localparam int InvertBit = 6;
  localparam int SelMsb = 5;
  // Reset values
  localparam logic [7:0] ResetPin2Cfg = 8'h29;
  localparam logic [7:0] ResetPin1Cfg = 8'h2E;
  localparam logic [7:0] ResetPin0Cfg = 8'h3F;
  localparam logic [7:0] ResetMem = 8'h00;
  // Selector code that releases a pin
  localparam logic [5:0] SelTriState = 6'h2E;
  // Identity values, arbitrary
  localparam logic [7:0] PartNumValue = 8'h5A;
  localparam logic [7:0] VersionValue = 8'h01;
  // Bit counter
  localparam logic [2:0] LastBit = 3'h7;
  localparam int MemDepth = 64;
endpackage : pin_config_pkg

//--- hdl/config_mem.sv
// Byte store for the general configuration registers
`timescale 1ns/1ps
module config_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic wrEn,
  input wire logic [5:0] wrAddr,
  input wire logic [7:0] wrData,
  // Read port, data registered
  input wire logic [5:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem_q [pin_config_pkg::MemDepth];

  // Storage, cleared only by reset so contents survive sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < pin_config_pkg::MemDepth; i++) begin
        mem_q[i] <= pin_config_pkg::ResetMem;
      end
    end else if (wrEn) begin
      mem_q[wrAddr] <= wrData;
    end
  end

  // Registered read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= pin_config_pkg::ResetMem;
    end else begin
      rdData <= mem_q[rdAddr];
    end
  end
endmodule : config_mem

//--- hdl/spi_pin_config.sv
// SPI register decode with command strobes, status reads and output pin configuration
//
// Contract
// - Bit 6 of each pin register inverts that pin's selected signal.
// - Pin 2 selector resets to 101001, the chip-ready low indication.
// - Bit 7 of pin 1 register sets drive strength for all pins.
// - Pin 1 selector resets to 101110, releasing the pin.
// - Pin 0 selector resets to 0x3F, the divided oscillator clock.
// - 0x30 to 0x3D: single access strobes, burst read returns status.
// - 0x00 to config end are read/write, with burst access supported.
`timescale 1ns/1ps
module spi_pin_config (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // SPI pins, synchronous to clk
  input wire logic spiCsLow,
  input wire logic spiSclk,
  input wire logic spiMosi,
  output logic spiMiso,
  // Device status
  input wire logic [7:0] chipStatus,
  input wire logic [7:0] statusData,
  output logic [3:0] statusAddr,
  // Command strobes
  output logic strobeValid,
  output logic [3:0] strobeCode,
  // Internal signals offered to the pins, indexed by selector code
  input wire logic [63:0] signalBus,
  // Output pins
  output logic general_output_2,
  output logic general_output_2Oe,
  output logic general_output_1,
  output logic general_output_1Oe,
  output logic general_output_0,
  output logic general_output_0Oe,
  output logic output_drive_strength
);
  logic [7:0] pin2Cfg_q;
  logic [7:0] pin1Cfg_q;
  logic [7:0] pin0Cfg_q;
  logic sclkPrev_q;
  logic [2:0] bitCnt_q;
  logic [7:0] shiftIn_q;
  logic [7:0] shiftOut_q;
  logic headerDone_q;
  logic isRead_q;
  logic isBurst_q;
  logic singleDone_q;
  logic [5:0] addr_q;
  logic [7:0] memRdData;
  logic sclkRise;
  logic sclkFall;
  logic byteEnd;
  logic [7:0] rxByte;
  logic dataWrite;
  logic [7:0] readByte;

  // Pin level from selector and invert bit
  function automatic logic pinLevel(input logic [7:0] cfg, input logic [63:0] bus);
    pinLevel = bus[cfg[pin_config_pkg::SelMsb:0]] ^ cfg[pin_config_pkg::InvertBit];
  endfunction : pinLevel

  // True when an address falls in the strobe/status range
  function automatic logic inStrobeRange(input logic [5:0] a);
    inStrobeRange = (a >= pin_config_pkg::AddrStrobeFirst) &&
                    (a <= pin_config_pkg::AddrStrobeLast);
  endfunction : inStrobeRange

  assign sclkRise = spiSclk && !sclkPrev_q && !spiCsLow;
  assign sclkFall = !spiSclk && sclkPrev_q && !spiCsLow;
  assign byteEnd = sclkRise && (bitCnt_q == pin_config_pkg::LastBit);
  assign rxByte = {shiftIn_q[6:0], spiMosi};
  // Data byte writes only in the config area, and only once for a single access
  assign dataWrite = byteEnd && headerDone_q && !isRead_q && !singleDone_q &&
                     (addr_q <= pin_config_pkg::AddrCfgLast);

  // Edge history of the serial clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkPrev_q <= 1'b0;
    end else begin
      sclkPrev_q <= spiSclk;
    end
  end

  // Bit counter and input shifter, framed by chip select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_q <= 3'h0;
      shiftIn_q <= 8'h00;
    end else if (spiCsLow) begin
      bitCnt_q <= 3'h0;
    end else if (sclkRise) begin
      bitCnt_q <= bitCnt_q + 3'h1;
      shiftIn_q <= rxByte;
    end
  end

  // Header decode and address walk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      headerDone_q <= 1'b0;
      isRead_q <= 1'b0;
      isBurst_q <= 1'b0;
      singleDone_q <= 1'b0;
      addr_q <= 6'h00;
    end else if (spiCsLow) begin
      headerDone_q <= 1'b0;
      singleDone_q <= 1'b0;
    end else if (byteEnd && !headerDone_q) begin
      headerDone_q <= 1'b1;
      isRead_q <= rxByte[pin_config_pkg::HdrRwBit];
      isBurst_q <= rxByte[pin_config_pkg::HdrBurstBit];
      addr_q <= rxByte[5:0];
    end else if (byteEnd) begin
      if (isBurst_q) begin
        addr_q <= addr_q + 6'h01;
      end else begin
        singleDone_q <= 1'b1;
      end
    end
  end

  // strobe on single access in range
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobeValid <= 1'b0;
      strobeCode <= 4'h0;
    end else begin
      strobeValid <= byteEnd && !headerDone_q && !rxByte[pin_config_pkg::HdrBurstBit] &&
                     inStrobeRange(rxByte[5:0]);
      if (byteEnd && !headerDone_q) begin
        strobeCode <= rxByte[3:0];
      end
    end
  end

  // Pin configuration registers; reset only, so sleep keeps them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin2Cfg_q <= pin_config_pkg::ResetPin2Cfg;
      pin1Cfg_q <= pin_config_pkg::ResetPin1Cfg;
      pin0Cfg_q <= pin_config_pkg::ResetPin0Cfg;
    end else if (dataWrite) begin
      case (addr_q)
        pin_config_pkg::AddrPin2Cfg: pin2Cfg_q <= {1'b0, rxByte[6:0]}; // Bit 7 reads zero
        pin_config_pkg::AddrPin1Cfg: pin1Cfg_q <= rxByte;
        pin_config_pkg::AddrPin0Cfg: pin0Cfg_q <= rxByte;
        default: ;
      endcase
    end
  end

  config_mem u_mem (
    .clk(clk),
    .rst(rst),
    .wrEn(dataWrite),
    .wrAddr(addr_q),
    .wrData(rxByte),
    .rdAddr(addr_q),
    .rdData(memRdData)
  );

  // Status address follows the walk pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusAddr <= 4'h0;
    end else begin
      statusAddr <= addr_q[3:0];
    end
  end

  // Read data mux; the memory answer lags the address by one clock
  always_comb begin
    readByte = 8'h00;
    if (addr_q == pin_config_pkg::AddrPin2Cfg) begin
      readByte = pin2Cfg_q;
    end else if (addr_q == pin_config_pkg::AddrPin1Cfg) begin
      readByte = pin1Cfg_q;
    end else if (addr_q == pin_config_pkg::AddrPin0Cfg) begin
      readByte = pin0Cfg_q;
    end else if (addr_q <= pin_config_pkg::AddrCfgLast) begin
      readByte = memRdData;
    end else if (inStrobeRange(addr_q) && isBurst_q) begin
      if (addr_q == pin_config_pkg::AddrPartNum) begin
        readByte = pin_config_pkg::PartNumValue;
      end else if (addr_q == pin_config_pkg::AddrVersion) begin
        readByte = pin_config_pkg::VersionValue;
      end else begin
        readByte = statusData;
      end
    end
  end

  // Output shifter: status byte during header, then read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftOut_q <= 8'h00;
      spiMiso <= 1'b0;
    end else if (spiCsLow) begin
      shiftOut_q <= {chipStatus[6:0], 1'b0};
      spiMiso <= chipStatus[7];
    end else if (sclkFall) begin
      if (bitCnt_q == 3'h0 && headerDone_q) begin
        // Single reads repeat the status byte after their one data byte
        if (isRead_q && !singleDone_q) begin
          spiMiso <= readByte[7];
          shiftOut_q <= {readByte[6:0], 1'b0};
        end else begin
          spiMiso <= chipStatus[7];
          shiftOut_q <= {chipStatus[6:0], 1'b0};
        end
      end else if (bitCnt_q != 3'h0) begin
        spiMiso <= shiftOut_q[7];
        shiftOut_q <= {shiftOut_q[6:0], 1'b0};
      end
    end
  end

  // Pin drivers, registered so outputs never glitch on selector changes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      general_output_2 <= 1'b0;
      general_output_1 <= 1'b0;
      general_output_0 <= 1'b0;
      general_output_2Oe <= 1'b0;
      general_output_1Oe <= 1'b0;
      general_output_0Oe <= 1'b0;
      output_drive_strength <= 1'b0;
    end else begin
      general_output_2 <= pinLevel(pin2Cfg_q, signalBus);
      general_output_1 <= pinLevel(pin1Cfg_q, signalBus);
      general_output_0 <= pinLevel(pin0Cfg_q, signalBus);
      general_output_2Oe <= pin2Cfg_q[pin_config_pkg::SelMsb:0] != pin_config_pkg::SelTriState;
      general_output_1Oe <= pin1Cfg_q[pin_config_pkg::SelMsb:0] != pin_config_pkg::SelTriState;
      general_output_0Oe <= pin0Cfg_q[pin_config_pkg::SelMsb:0] != pin_config_pkg::SelTriState;
      output_drive_strength <= pin1Cfg_q[pin_config_pkg::DriveBit];
    end
  end
endmodule : spi_pin_config

//--- sim/spi_host_model.sv
// SPI master model standing in for the host microcontroller
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input wire logic clk,
  // SPI pins
  output logic csLow,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  // Bytes read back, one pulse each
  output logic rdValid,
  output logic [7:0] rdByte,
  // Status byte seen during each header, one pulse
  output logic stValid,
  output logic [7:0] stByte
);
  // Idle bus: deselected, clock parked low
  initial begin
    csLow = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    rdValid = 1'b0;
    rdByte = 8'h00;
    stValid = 1'b0;
    stByte = 8'h00;
  end

  // Mode 0, MSB first; four clocks per phase keeps the slow-SPI spacing
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      mosi = tx[b];
      repeat (4) @(negedge clk);
      rx[b] = miso;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
  endtask : shift

  task automatic frame(input logic [7:0] hdr, input logic [7:0] wd, input int n);
    logic [7:0] rx;
    csLow = 1'b0;
    shift(hdr, rx);
    // Header answer is the chip status; the extra low clock is within spacing
    stByte = rx;
    stValid = 1'b1;
    @(negedge clk);
    stValid = 1'b0;
    for (int k = 0; k < n; k++) begin
      shift(wd + 8'(k), rx);
      rdByte = rx;
      rdValid = hdr[7];
      @(negedge clk);
      rdValid = 1'b0;
    end
    repeat (2) @(negedge clk);
    csLow = 1'b1;
    // Released data line must not look held, so flip it
    mosi = ~mosi;
    repeat (3) @(negedge clk);
  endtask : frame
endmodule : spi_host_model

//--- sim/spi_pin_config_monitor.sv
// Port-level assertions for the SPI pin configuration block
`timescale 1ns/1ps
module spi_pin_config_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // SPI pins
  input wire logic spiCsLow,
  input wire logic spiSclk,
  input wire logic spiMiso,
  // Strobes and signals
  input wire logic strobeValid,
  input wire logic [3:0] strobeCode,
  input wire logic [63:0] signalBus,
  // Output pins
  input wire logic general_output_2,
  input wire logic general_output_2Oe,
  input wire logic general_output_1,
  input wire logic general_output_1Oe,
  input wire logic general_output_0,
  input wire logic general_output_0Oe,
  input wire logic output_drive_strength
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_strobe_one_cycle: assert property (strobeValid |=> !strobeValid)
    else $error("strobe longer than one cycle");
  chk_strobe_in_frame: assert property (strobeValid |-> !$past(spiCsLow))
    else $error("strobe outside a frame");
  chk_strobe_after_rise: assert property (strobeValid |->
    ($past(spiSclk, 2) && !$past(spiSclk, 3)) || ($past(spiSclk) && !$past(spiSclk, 2)))
    else $error("strobe not tied to a clock rise");
  chk_strobe_code_range: assert property (strobeValid |-> strobeCode <= 4'hD)
    else $error("strobe code out of range");
  // Config outputs only move when a write lands, which is inside a frame
  chk_cfg_in_frame: assert property (!$past(rst, 2) && !$stable({general_output_2Oe,
    general_output_1Oe, general_output_0Oe, output_drive_strength}) |-> !$past(spiCsLow))
    else $error("pin config changed outside a frame");
  chk_pins_follow_bus: assert property (!$past(rst) && spiCsLow && $past(spiCsLow) &&
    $stable(signalBus) |=> $stable({general_output_2, general_output_1, general_output_0}))
    else $error("pin moved without cause");
  chk_miso_on_fall: assert property (!$stable(spiMiso) && !$past(spiCsLow) &&
    !$past(spiCsLow, 2) && !$past(spiCsLow, 3) |->
    ($past(spiSclk, 3) && !$past(spiSclk, 2)) || ($past(spiSclk, 2) && !$past(spiSclk)))
    else $error("miso shifted off a falling clock");
  chk_reset_pins: assert property ($fell(rst) |=> general_output_2Oe &&
    !general_output_1Oe && general_output_0Oe && !output_drive_strength)
    else $error("pin enables wrong after reset");
endmodule : spi_pin_config_monitor

bind spi_pin_config spi_pin_config_monitor spi_pin_config_monitor_i (.clk, .rst, .spiCsLow,
  .spiSclk, .spiMiso, .strobeValid, .strobeCode, .signalBus, .general_output_2,
  .general_output_2Oe, .general_output_1, .general_output_1Oe, .general_output_0,
  .general_output_0Oe, .output_drive_strength);

//--- sim/testbench.sv
// Self-checking bench for the SPI pin configuration block
`timescale 1ns/1ps
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spiCsLow, spiSclk, spiMosi, spiMiso, rdValid, strobeValid, drv, stValid;
  logic g2, g2Oe, g1, g1Oe, g0, g0Oe;
  logic [7:0] chipStatus = 8'hA5;
  logic [7:0] statusData = 8'h00;
  logic [3:0] statusHi = 4'h0;
  logic [7:0] rdByte, want, c, stByte, pin1Val;
  logic [3:0] statusAddr, strobeCode;
  logic [63:0] signalBus = 64'h0;
  logic [7:0] expQ[$];
  logic [3:0] strobeQ[$];
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  integer seed = 8;

  always #12.5 clk = ~clk;

  // Status source answers the address the block presents, so statusAddr is checked too
  always @(negedge clk) statusData <= {statusHi, statusAddr};

  spi_pin_config spi_pin_config_i (.clk(clk), .rst(rst), .spiCsLow(spiCsLow),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso), .chipStatus(chipStatus),
    .statusData(statusData), .statusAddr(statusAddr), .strobeValid(strobeValid),
    .strobeCode(strobeCode), .signalBus(signalBus), .general_output_2(g2),
    .general_output_2Oe(g2Oe), .general_output_1(g1), .general_output_1Oe(g1Oe),
    .general_output_0(g0), .general_output_0Oe(g0Oe), .output_drive_strength(drv));
  spi_host_model host_i (.clk(clk), .csLow(spiCsLow), .sclk(spiSclk), .mosi(spiMosi),
    .miso(spiMiso), .rdValid(rdValid), .rdByte(rdByte), .stValid(stValid), .stByte(stByte));

  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Oldest note against each result; an unannounced strobe expects code F and fails
  always @(posedge clk) begin
    if (rdValid) begin
      want = expQ.size() != 0 ? expQ.pop_front() : 8'hXX;
      `CHK(rdByte, want, "read byte")
    end
    if (strobeValid) begin
      want = {4'h0, strobeQ.size() != 0 ? strobeQ.pop_front() : 4'hF};
      `CHK(strobeCode, want[3:0], "strobe code")
    end
    if (stValid) begin
      `CHK(stByte, chipStatus, "status byte")
    end
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      give_verdict();
    end
  end

  // Pin level is the selected bus bit through inversion; code 2E releases the pin
  task automatic chk_pin(input logic [7:0] cfg, input logic lvl, input logic oe);
    `CHK({oe, lvl}, {cfg[5:0] != 6'h2E, signalBus[cfg[5:0]] ^ cfg[6]}, "pin")
  endtask : chk_pin

  initial begin
    signalBus = {$random(seed), $random(seed)};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_pin(8'h29, g2, g2Oe);
    chk_pin(8'h3F, g0, g0Oe);
    `CHK({g1Oe, drv}, 2'b00, "pin1 reset")
    expQ = '{8'h29, 8'h2E, 8'h3F};
    host_i.frame(8'hC0, 8'h00, 3);
    host_i.frame(8'h02, 8'h06, 1);
    chk_pin(8'h06, g0, g0Oe);
    // Single read gives one data byte, then the status byte again
    expQ.push_back(8'h06);
    expQ.push_back(chipStatus);
    host_i.frame(8'h82, 8'h00, 2);
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'hAC : 8'($random(seed));
      host_i.frame(8'h40, c, 3);
      signalBus = {$random(seed), $random(seed)};
      chipStatus = 8'($random(seed));
      repeat (3) @(negedge clk);
      chk_pin(c, g2, g2Oe);
      chk_pin(c + 8'h01, g1, g1Oe);
      chk_pin(c + 8'h02, g0, g0Oe);
      pin1Val = c + 8'h01;
      `CHK(drv, pin1Val[7], "drive strength")
      expQ = '{c & 8'h7F, c + 8'h01, c + 8'h02};
      host_i.frame(8'hC0, 8'h00, 3);
    end
    // single accesses strobe, read or write
    for (int a = 8'h30; a <= 8'h3D; a++) begin
      strobeQ.push_back(4'(a));
      host_i.frame(8'(a) | ((a % 2) != 0 ? 8'h80 : 8'h00), 8'h00, 0);
    end
    // burst reads return status, burst write there is ignored
    statusHi = 4'($random(seed));
    expQ = '{8'h5A, 8'h01, {statusHi, 4'h5}, 8'h00};
    host_i.frame(8'hF0, 8'h00, 1);
    host_i.frame(8'hF1, 8'h00, 1);
    host_i.frame(8'hF5, 8'h00, 1);
    host_i.frame(8'h75, 8'h11, 1);
    // 0x2F, just past the config area, not writable
    host_i.frame(8'h2F, 8'h77, 1);
    host_i.frame(8'hAF, 8'h00, 1);
    // Single write keeps only its first data byte
    host_i.frame(8'h2C, 8'h44, 2);
    host_i.frame(8'h6D, 8'h91, 2);
    expQ = '{8'h44, 8'h91, 8'h92};
    host_i.frame(8'hEC, 8'h00, 3);
    `CHK(expQ.size(), 0, "reads missing")
    give_verdict();
  end
endmodule : testbench
